//--- hw/bie_regs.svh
`ifndef BIE_REGS_SVH
`define BIE_REGS_SVH
// Register indices on the plain register port
`define BIE_REG_ACC      4'h0
`define BIE_REG_PAGE     4'h1
`define BIE_REG_STATUS   4'h2
`define BIE_REG_PC       4'h3
`define BIE_REG_FLUSHES  4'h4
// Field positions
`define BIE_STAT_ZERO    0
`define BIE_STAT_BUSY    1
`define BIE_PAGE_HI      4
`define BIE_PAGE_LO      3
`define BIE_DEST_BIT     7
// Reset values
`define BIE_ACC_RST      8'h00
`define BIE_PAGE_RST     5'h00
`define BIE_PC_RST       13'h0000
`define BIE_FLUSH_RST    8'h00
// Instruction word opcode fields
`define BIE_OP_DEC_SKIP  6'h0b
`define BIE_OP_INC_SKIP  6'h0f
`define BIE_OP_INC       6'h0a
`define BIE_OP_OR_FILE   6'h04
`define BIE_OP_OR_LIT    6'h38
`define BIE_BRANCH_PFX   3'h5
// Instruction cycle counts
`define BIE_CYC_SINGLE   2'h1
`define BIE_CYC_DOUBLE   2'h2
`endif

//--- hw/bie_pkg.sv
package bie_pkg;
	// Operations handled by this execution group
	typedef enum logic [2:0]
	{
		OP_NONE,
		OP_DEC_SKIP,
		OP_INC_SKIP,
		OP_BRANCH,
		OP_OR_LIT,
		OP_INC,
		OP_OR_FILE
	} bie_op_t;

	// Sequencer states
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_EXEC,
		ST_NOP
	} bie_state_t;

	// Whole-byte zero test
	function automatic logic isZero(input logic [7:0] v);
		isZero = (v == 8'h00);
	endfunction
endpackage

//--- hw/bie_op_if.sv
`timescale 1ns/1ns
interface bie_op_if;
	import bie_pkg::*;
	bie_op_t    op;
	logic [7:0] accVal;
	logic [7:0] fileVal;
	logic [7:0] literal;
	logic [7:0] result;
	logic       zeroRes;
	logic       skipNext;
	logic       setsZero;

	modport core
	(
		output op, accVal, fileVal, literal,
		input  result, zeroRes, skipNext, setsZero
	);
	modport alu
	(
		input  op, accVal, fileVal, literal,
		output result, zeroRes, skipNext, setsZero
	);
endinterface

//--- hw/bie_alu.sv
`timescale 1ns/1ns
module bie_alu
	import bie_pkg::*;
(
	bie_op_if.alu opBus
);
	// Byte increment, shared by both increment forms
	function automatic logic [7:0] incByte(input logic [7:0] v);
		incByte = v + 8'h01;
	endfunction

	wire [7:0] incVal = incByte(opBus.fileVal);
	wire [7:0] decVal = opBus.fileVal - 8'h01;
	wire [7:0] orFile = opBus.accVal | opBus.fileVal;
	wire [7:0] orLit  = opBus.accVal | opBus.literal;
	wire       isInc  = (opBus.op == OP_INC_SKIP) || (opBus.op == OP_INC);

	// Result selection per operation
	assign opBus.result = (opBus.op == OP_DEC_SKIP) ? decVal :
		isInc ? incVal :
		(opBus.op == OP_OR_LIT) ? orLit :
		(opBus.op == OP_OR_FILE) ? orFile :
		opBus.accVal;
	assign opBus.zeroRes  = isZero(opBus.result);
	// Skip only for the two skip forms on a zero result
	assign opBus.skipNext = ((opBus.op == OP_DEC_SKIP) || (opBus.op == OP_INC_SKIP))
		&& opBus.zeroRes;
	// Skip forms leave flags alone
	assign opBus.setsZero = (opBus.op == OP_OR_LIT) || (opBus.op == OP_INC)
		|| (opBus.op == OP_OR_FILE);
endmodule

//--- hw/bie_branch.sv
`timescale 1ns/1ns
`include "bie_regs.svh"
module bie_branch
	import bie_pkg::*;
(
	input  wire logic [10:0] literal,
	input  wire logic [4:0]  pageLatch,
	output      logic [12:0] target
);
	// Page bits above the 11-bit literal
	assign target = {pageLatch[`BIE_PAGE_HI:`BIE_PAGE_LO], literal};
endmodule

//--- hw/bie_exec_core.sv
// Functional notes
// - Decrement-and-skip writes the file value minus one to the destination, flags untouched.
// - A zero decrement result replaces the next instruction by a no-operation (two cycles).
// - Increment-and-skip writes file plus one, flags untouched, and skips on a wrap to zero.
// - Destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - The branch loads its 11-bit literal (0..2047) into program counter bits 10..0.
// - The branch takes program counter bits 12..11 from page latch bits 4..3.
// - The branch always takes two cycles since the following fetch is flushed.
// - OR-literal ORs the accumulator with an 8-bit literal into the accumulator, sets zero.
// - Plain increment writes file plus one to the destination and updates zero, no skip.
// - OR-with-file ORs accumulator and file register into the destination, updates zero.
`timescale 1ns/1ns
`include "bie_regs.svh"
module bie_exec_core
	import bie_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 7
)
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic              instrValid,
	input  wire logic [13:0]       instrWord,
	output      logic              instrReady,
	output      logic [ADDR_W-1:0] fileAddr,
	output      logic              fileRdEn,
	input  wire logic [DATA_W-1:0] fileRdData,
	output      logic              fileWrEn,
	output      logic [DATA_W-1:0] fileWrData,
	output      logic              pcLoad,
	output      logic [12:0]       pcTarget,
	output      logic              flushNext,
	output      logic              retire,
	output      logic [1:0]        retireCycles,
	output      logic              zeroFlag,
	input  wire logic [3:0]        regAddr,
	input  wire logic [15:0]       regWrData,
	input  wire logic              regWrEn,
	input  wire logic              regRdEn,
	output      logic [15:0]       regRdData
);
	// Sequencer and instruction latches
	bie_state_t        state_q;
	bie_state_t        state_d;
	bie_op_t           op_q;
	logic              dest_q;
	logic [10:0]       literal_q;
	logic [ADDR_W-1:0] fileAddr_q;
	logic              fileRdEn_q;
	// Architectural state
	logic [7:0]        acc_q;
	logic [7:0]        acc_d;
	logic              zero_q;
	logic              zero_d;
	logic [4:0]        page_q;
	logic [12:0]       pcTarget_q;
	logic [7:0]        flushes_q;
	// Output strobes
	logic              fileWrEn_q;
	logic [7:0]        fileWrData_q;
	logic              pcLoad_q;
	logic              flushNext_q;
	logic              retire_q;
	logic [1:0]        retireCycles_q;
	logic [15:0]       regRdData_q;

	// Opcode decode of an incoming word
	function automatic bie_op_t decodeOp(input logic [13:0] w);
		decodeOp = OP_NONE;
		if (w[13:11] == `BIE_BRANCH_PFX)
			decodeOp = OP_BRANCH;
		else if (w[13:8] == `BIE_OP_DEC_SKIP)
			decodeOp = OP_DEC_SKIP;
		else if (w[13:8] == `BIE_OP_INC_SKIP)
			decodeOp = OP_INC_SKIP;
		else if (w[13:8] == `BIE_OP_INC)
			decodeOp = OP_INC;
		else if (w[13:8] == `BIE_OP_OR_FILE)
			decodeOp = OP_OR_FILE;
		else if (w[13:8] == `BIE_OP_OR_LIT)
			decodeOp = OP_OR_LIT;
	endfunction

	// Decode and acceptance
	wire bie_op_t inOp      = decodeOp(instrWord);
	wire          accept    = instrValid && (state_q == ST_IDLE);
	wire          takeOp    = accept && (inOp != OP_NONE);
	wire          inUsesFile = (inOp == OP_DEC_SKIP) || (inOp == OP_INC_SKIP)
		|| (inOp == OP_INC) || (inOp == OP_OR_FILE);
	wire          execNow   = (state_q == ST_EXEC);
	wire          isFileOp  = (op_q == OP_DEC_SKIP) || (op_q == OP_INC_SKIP)
		|| (op_q == OP_INC) || (op_q == OP_OR_FILE);

	// Arithmetic unit link
	bie_op_if opBus();
	assign opBus.op      = execNow ? op_q : OP_NONE;
	assign opBus.accVal  = acc_q;
	assign opBus.fileVal = fileRdData;
	assign opBus.literal = literal_q[7:0];

	bie_alu u_alu
	(
		.opBus (opBus.alu)
	);

	// Branch target from literal and page latch
	logic [12:0] branchTarget;
	bie_branch u_branch
	(
		.literal   (literal_q),
		.pageLatch (page_q),
		.target    (branchTarget)
	);

	// Execution decisions in the EXEC cycle
	wire toFile    = execNow && isFileOp && dest_q;
	wire toAcc     = execNow && ((isFileOp && !dest_q) || (op_q == OP_OR_LIT));
	wire doBranch  = execNow && (op_q == OP_BRANCH);
	wire needFlush = doBranch || (execNow && opBus.skipNext);

	// Software register writes
	wire swAcc  = regWrEn && (regAddr == `BIE_REG_ACC);
	wire swPage = regWrEn && (regAddr == `BIE_REG_PAGE);
	wire swStat = regWrEn && (regAddr == `BIE_REG_STATUS);

	// Accumulator: instruction result wins over a software write
	assign acc_d = toAcc ? opBus.result :
		swAcc ? regWrData[7:0] : acc_q;

	// Zero flag: instruction update wins over a software write
	assign zero_d = (execNow && opBus.setsZero) ? opBus.zeroRes :
		swStat ? regWrData[`BIE_STAT_ZERO] : zero_q;

	// Next sequencer state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (takeOp)
					state_d = ST_EXEC;
			end
			ST_EXEC:
			begin
				if (needFlush)
					state_d = ST_NOP;
				else
					state_d = ST_IDLE;
			end
			ST_NOP:
			begin
				state_d = ST_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Instruction latch on acceptance
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			op_q       <= OP_NONE;
			dest_q     <= 1'b0;
			literal_q  <= 11'h000;
			fileAddr_q <= '0;
			fileRdEn_q <= 1'b0;
		end
		else
		begin
			fileRdEn_q <= takeOp && inUsesFile;
			if (takeOp)
			begin
				op_q       <= inOp;
				dest_q     <= instrWord[`BIE_DEST_BIT];
				literal_q  <= instrWord[10:0];
				fileAddr_q <= instrWord[ADDR_W-1:0];
			end
		end
	end

	// Architectural registers
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			acc_q  <= `BIE_ACC_RST;
			zero_q <= 1'b0;
			page_q <= `BIE_PAGE_RST;
		end
		else
		begin
			acc_q  <= acc_d;
			zero_q <= zero_d;
			if (swPage)
				page_q <= regWrData[4:0];
		end
	end

	// File write-back strobe and data
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			fileWrEn_q   <= 1'b0;
			fileWrData_q <= 8'h00;
		end
		else
		begin
			fileWrEn_q <= toFile;
			if (toFile)
				fileWrData_q <= opBus.result;
		end
	end

	// Branch load and flush of the following fetch
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			pcLoad_q    <= 1'b0;
			pcTarget_q  <= `BIE_PC_RST;
			flushNext_q <= 1'b0;
			flushes_q   <= `BIE_FLUSH_RST;
		end
		else
		begin
			pcLoad_q    <= doBranch;
			flushNext_q <= needFlush;
			if (doBranch)
				pcTarget_q <= branchTarget;
			if (needFlush)
				flushes_q <= flushes_q + 8'h01;
		end
	end

	// Retire pulse with the instruction's cycle count
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			retire_q       <= 1'b0;
			retireCycles_q <= 2'h0;
		end
		else
		begin
			retire_q <= (execNow && !needFlush) || (state_q == ST_NOP);
			if (execNow && !needFlush)
				retireCycles_q <= `BIE_CYC_SINGLE;
			else if (state_q == ST_NOP)
				retireCycles_q <= `BIE_CYC_DOUBLE;
		end
	end

	// Register read selection
	wire [15:0] statusWord = {14'h0000, (state_q != ST_IDLE), zero_q};
	wire [15:0] rdMux =
		(regAddr == `BIE_REG_ACC)     ? {8'h00, acc_q} :
		(regAddr == `BIE_REG_PAGE)    ? {11'h000, page_q} :
		(regAddr == `BIE_REG_STATUS)  ? statusWord :
		(regAddr == `BIE_REG_PC)      ? {3'h0, pcTarget_q} :
		(regAddr == `BIE_REG_FLUSHES) ? {8'h00, flushes_q} : 16'h0000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			regRdData_q <= 16'h0000;
		else
			regRdData_q <= regRdEn ? rdMux : 16'h0000;
	end

	// Output drive
	assign instrReady   = (state_q == ST_IDLE);
	assign fileAddr     = fileAddr_q;
	assign fileRdEn     = fileRdEn_q;
	assign fileWrEn     = fileWrEn_q;
	assign fileWrData   = fileWrData_q;
	assign pcLoad       = pcLoad_q;
	assign pcTarget     = pcTarget_q;
	assign flushNext    = flushNext_q;
	assign retire       = retire_q;
	assign retireCycles = retireCycles_q;
	assign zeroFlag     = zero_q;
	assign regRdData    = regRdData_q;
endmodule

//--- test/bie_exec_core_monitor.sv
`timescale 1ns/1ns
module bie_exec_core_monitor
	import bie_pkg::*;
#(
	parameter int DATA_W = 8,
	parameter int ADDR_W = 7
)
(
	input wire logic              clock,
	input wire logic              rst_n,
	input wire logic [13:0]       instrWord,
	input wire logic              instrReady,
	input wire logic [ADDR_W-1:0] fileAddr,
	input wire logic              fileRdEn,
	input wire logic              fileWrEn,
	input wire logic [DATA_W-1:0] fileWrData,
	input wire logic              pcLoad,
	input wire logic [12:0]       pcTarget,
	input wire logic              flushNext,
	input wire logic              retire,
	input wire logic [1:0]        retireCycles,
	input wire logic              zeroFlag
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Branch timing and target
	AST_BR_FLUSH: assert property (pcLoad |-> flushNext)
		else $error("branch without flush");
	AST_BR_DONE: assert property (pcLoad |=> retire && retireCycles == 2'h2)
		else $error("branch not two cycles");
	AST_BR_LIT: assert property (pcLoad |-> pcTarget[10:0] == $past(instrWord[10:0], 2))
		else $error("branch literal wrong");
	// Skip by inserted idle slot
	AST_SKIP_DONE: assert property (flushNext |-> !instrReady ##1 (retire && retireCycles == 2'h2))
		else $error("skip not two cycles");
	AST_SKIP_ZERO: assert property (flushNext |-> $stable(zeroFlag))
		else $error("skip touched zero");
	AST_SKIP_RES: assert property (flushNext && fileWrEn |-> fileWrData == '0)
		else $error("skip on nonzero result");
	// File operand handling
	AST_SINGLE: assert property (fileRdEn |=> retire ^ flushNext)
		else $error("file op end wrong");
	AST_ADDR: assert property (fileRdEn |-> fileAddr == $past(instrWord[ADDR_W-1:0]))
		else $error("file address wrong");
endmodule

bind bie_exec_core bie_exec_core_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) mon
(
	.clock, .rst_n, .instrWord, .instrReady, .fileAddr, .fileRdEn, .fileWrEn,
	.fileWrData, .pcLoad, .pcTarget, .flushNext, .retire, .retireCycles, .zeroFlag
);

//--- test/bie_file_model.sv
`timescale 1ns/1ns
module bie_file_model
	import bie_pkg::*;
(
	input  wire logic       clock,
	input  wire logic [6:0] fileAddr,
	input  wire logic       fileRdEn,
	output      logic [7:0] fileRdData,
	input  wire logic       fileWrEn,
	input  wire logic [7:0] fileWrData
);
	logic [7:0] mem [128];
	logic [7:0] junk = 8'ha5;
	// Data only while read is open
	assign fileRdData = fileRdEn ? mem[fileAddr] : junk;
	// Write-back, junk keeps toggling
	always @(posedge clock)
	begin
		junk <= ~junk;
		if (fileWrEn)
			mem[fileAddr] <= fileWrData;
	end
endmodule

//--- test/tb_bie_exec_core.sv
`timescale 1ns/1ns
`include "bie_regs.svh"
module tb_bie_exec_core
	import bie_pkg::*;
;
	logic        clock = 0, rst_n = 0, instrValid = 0, regWrEn = 0, regRdEn = 0;
	logic [13:0] instrWord = 0;
	logic [3:0]  regAddr = 0;
	logic [15:0] regWrData = 0, regRdData;
	logic [6:0]  fileAddr;
	logic [7:0]  fileRdData, fileWrData;
	logic [12:0] pcTarget;
	logic [1:0]  retireCycles;
	logic        instrReady, fileRdEn, fileWrEn, pcLoad, flushNext, retire, zeroFlag;
	int          errors = 0, n_compared = 0;
	logic [4:0]  pg [3] = '{5'h18, 5'h08, 5'h07};
	logic [10:0] lt [3] = '{11'h7ff, 11'h000, 11'h123};

	bie_exec_core dut (.clock, .rst_n, .instrValid, .instrWord, .instrReady, .fileAddr,
		.fileRdEn, .fileRdData, .fileWrEn, .fileWrData, .pcLoad, .pcTarget, .flushNext,
		.retire, .retireCycles, .zeroFlag, .regAddr, .regWrData, .regWrEn, .regRdEn,
		.regRdData);
	bie_file_model mdl (.clock, .fileAddr, .fileRdEn, .fileRdData, .fileWrEn, .fileWrData);

	// Clock
	initial
	forever #4 clock = ~clock;

	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrEn <= 1'b0;
	endtask

	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRdEn <= 1'b0;
		#1 chk("reg", e, regRdData);
	endtask

	// One instruction, then accumulator, zero and file checks
	task op(input logic [13:0] w, input int c, input logic [12:0] pc, input logic [6:0] a,
		input logic [7:0] fi, input logic [7:0] fe, input logic [7:0] ae, input logic z);
		int k;
		logic fl, pl;
		fl = 0;
		pl = 0;
		mdl.mem[a] = fi;
		@(posedge clock);
		instrValid <= 1'b1;
		instrWord <= w;
		@(posedge clock);
		instrValid <= 1'b0;
		for (k = 1; k < 6; k++)
		begin
			@(posedge clock);
			#1;
			fl |= flushNext;
			pl |= pcLoad;
			if (pcLoad)
				chk("target", {3'h0, pc}, {3'h0, pcTarget});
			if (retire)
				break;
		end
		// Retire shows k edges after the taking edge: one for single, two for double
		chk("cycles", c, k);
		chk("retCyc", c, retireCycles);
		chk("flush", c - 1, fl);
		chk("load", w[13:11] == `BIE_BRANCH_PFX, pl);
		chk("zeroPin", {15'h0, z}, {15'h0, zeroFlag});
		rd(`BIE_REG_ACC, {8'h0, ae});
		rd(`BIE_REG_STATUS, {15'h0, z});
		chk("file", fe, mdl.mem[a]);
	endtask

	task finish_test;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog, far beyond the 133 or so cycles needed
	initial
	begin
		#40000;
		errors++;
		finish_test();
	end

	initial
	begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd(`BIE_REG_ACC, 16'h0000);
		rd(`BIE_REG_STATUS, 16'h0000);
		rd(4'h5, 16'h0000);
		wr(`BIE_REG_PC, 16'h1234);
		rd(`BIE_REG_PC, 16'h0000);
		$display("test regs done");
		op({`BIE_OP_OR_LIT, 8'h00}, 1, 0, 0, 8'h11, 8'h11, 8'h00, 1);
		op({`BIE_OP_OR_LIT, 8'h5a}, 1, 0, 0, 8'h11, 8'h11, 8'h5a, 0);
		op({`BIE_OP_OR_LIT, 8'h81}, 1, 0, 0, 8'h11, 8'h11, 8'hdb, 0);
		op({`BIE_OP_INC, 8'h85}, 1, 0, 5, 8'hff, 8'h00, 8'hdb, 1);
		op({`BIE_OP_INC, 8'h06}, 1, 0, 6, 8'h41, 8'h41, 8'h42, 0);
		op({`BIE_OP_DEC_SKIP, 8'h87}, 2, 0, 7, 8'h01, 8'h00, 8'h42, 0);
		op({`BIE_OP_DEC_SKIP, 8'h08}, 1, 0, 8, 8'h02, 8'h02, 8'h01, 0);
		op({`BIE_OP_INC_SKIP, 8'h09}, 2, 0, 9, 8'hff, 8'hff, 8'h00, 0);
		op({`BIE_OP_INC_SKIP, 8'h8a}, 1, 0, 10, 8'h7f, 8'h80, 8'h00, 0);
		op({`BIE_OP_OR_FILE, 8'h00}, 1, 0, 0, 8'h00, 8'h00, 8'h00, 1);
		op({`BIE_OP_OR_LIT, 8'h0f}, 1, 0, 0, 8'h11, 8'h11, 8'h0f, 0);
		op({`BIE_OP_OR_FILE, 8'hff}, 1, 0, 127, 8'h30, 8'h3f, 8'h0f, 0);
		$display("test data ops done");
		// Page bits inside the selected pair (both set, lower only) and below it
		for (int i = 0; i < 3; i++)
		begin
			wr(`BIE_REG_PAGE, {11'h0, pg[i]});
			op({`BIE_BRANCH_PFX, lt[i]}, 2, {pg[i][4:3], lt[i]}, 0, 0, 0, 8'h0f, 0);
		end
		rd(`BIE_REG_PC, 16'h0123);
		rd(`BIE_REG_FLUSHES, 16'h0005);
		$display("test branch done");
		finish_test();
	end
endmodule
